// *** hdl/ndr_defines.svh ***
// Purpose: constants of the node discovery and response timing block
// Assumes: one 100 MHz clock, APB data 32 bits wide
// Notes: times are counted in bus bit times
// Notes on behaviour
// - switch enable starts sync control frames downstream
// - upstream node answers for a silent last node
// - slave answers four times setting plus seven bits
// - A to B pass delay seven bits
// - B to A pass delay nine bits
// - response within plus/minus two bits accepted, forwarded
// - outside window detected, expectation shifted -4..+15
// - master aligns expectation to first slave
// - slave realigns to newly discovered downstream slave
// - last slave originates the sync response frame
// - errors may flag during discovery, then cease
// - discovery frame carries time, target copies it
// - master reports discovery done with code 18h
`ifndef NDR_DEFINES_SVH
`define NDR_DEFINES_SVH
`define NDR_OFF_CTRL 8'h00
`define NDR_OFF_SWCTL 8'h04
`define NDR_OFF_RESP 8'h08
`define NDR_OFF_DISC 8'h0C
`define NDR_OFF_INTTYPE 8'h10
`define NDR_OFF_STATUS 8'h14
`define NDR_CTRL_MASTER_BIT 0
`define NDR_CTRL_INV_BIT 1
`define NDR_SW_EN_BIT 0
`define NDR_ST_DONE_BIT 0
`define NDR_ST_MISS_BIT 1
`define NDR_ST_ACTIVE_BIT 2
`define NDR_ST_ADJ_LSB 8
`define NDR_RESP_RST 8'h80
`define NDR_DISC_RST 8'h00
`define NDR_RESP_MULT 4
`define NDR_RESP_ADD 7
`define NDR_DOWNSTREAM_PASS_DELAY 7
`define NDR_UPSTREAM_PASS_DELAY 9
`define NDR_WIN 2
`define NDR_ADJ_MIN -4
`define NDR_ADJ_MAX 15
`define NDR_DONE_CODE 8'h18
`define NDR_FRAME_BITS 1024
`endif

// *** hdl/ndr_pkg.sv ***
// Purpose: shared types of the discovery timing block
// Assumes: nothing
// Notes: constants live in ndr_defines.svh
package ndr_pkg;
   typedef enum logic [2:0] {
      NDR_REG_CTRL = 3'b000,
      NDR_REG_SWCTL = 3'b001,
      NDR_REG_RESP = 3'b010,
      NDR_REG_DISC = 3'b011,
      NDR_REG_INTTYPE = 3'b100,
      NDR_REG_STATUS = 3'b101,
      NDR_REG_NONE = 3'b111
   } ndr_reg_e;
   typedef logic signed [5:0] ndr_adj_t;
   typedef logic [10:0] ndr_cnt_t;
endpackage

// *** hdl/ndr_bit_if.sv ***
// Purpose: bit-timed lane between the node and its pass delay lines
// Assumes: tick is one pclk cycle per bus bit
// Notes: bit 1 is the frame marker, bit 0 the line data
`timescale 1ns/10ps
interface ndr_bit_if;
   logic tick;
   logic [1:0] din;
   logic [1:0] dout;
   modport src (output tick, output din, input dout);
   modport dly (input tick, input din, output dout);
endinterface

// *** hdl/ndr_sync.sv ***
// Purpose: two-flop synchroniser for pins from the link
// Assumes: multi-bit fields are held stable for a whole bit time
// Notes: first stage feeds the second stage only
`timescale 1ns/10ps
module ndr_sync #(parameter int W = 1) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// *** hdl/ndr_delay.sv ***
// Purpose: fixed pass delay of DEPTH bit times
// Assumes: tick marks one bus bit
// Notes: the consumer's output flop adds one more bit
`timescale 1ns/10ps
module ndr_delay #(parameter int DEPTH = 6) (
   input wire logic pclk,
   input wire logic presetn,
   ndr_bit_if.dly lane
);
   logic [1:0] pipe_reg [DEPTH];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pipe_reg[0] <= 2'h0;
      end else if (lane.tick) begin
         pipe_reg[0] <= lane.din;
      end
   end
   genvar i;
   generate
      for (i = 1; i < DEPTH; i++) begin : g_stage
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pipe_reg[i] <= 2'h0;
            end else if (lane.tick) begin
               pipe_reg[i] <= pipe_reg[i-1];
            end
         end
      end
   endgenerate
   assign lane.dout = pipe_reg[DEPTH-1];
endmodule

// *** hdl/ndr_node.sv ***
// Purpose: node discovery sequencing and response timing of one node
// Assumes: link bit clock far slower than pclk, APB zero-wait slave
// Notes: bit counter restarts at each sync control frame start
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "ndr_defines.svh"
module ndr_node import ndr_pkg::*; #(
   parameter int FRAME_BITS = `NDR_FRAME_BITS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_clk,
   input wire logic a_rx_data,
   input wire logic a_rx_sof,
   input wire logic a_rx_disc_valid,
   input wire logic [7:0] a_rx_disc_val,
   input wire logic b_rx_data,
   input wire logic b_rx_srf,
   output logic a_tx_data,
   output logic a_tx_srf,
   output logic b_tx_data,
   output logic b_tx_sof,
   output logic b_tx_disc_valid,
   output logic [7:0] b_tx_disc_val
);
   localparam logic signed [11:0] WIN_S = 12'(`NDR_WIN);
   localparam logic signed [11:0] UP_S = 12'(`NDR_UPSTREAM_PASS_DELAY);
   localparam ndr_adj_t ADJ_MIN = 6'(`NDR_ADJ_MIN);
   localparam ndr_adj_t ADJ_MAX = 6'(`NDR_ADJ_MAX);
   localparam ndr_cnt_t LAST_BIT = 11'(FRAME_BITS - 1);

   function automatic ndr_reg_e reg_dec(input logic [7:0] a);
      unique case (a)
         `NDR_OFF_CTRL: reg_dec = NDR_REG_CTRL;
         `NDR_OFF_SWCTL: reg_dec = NDR_REG_SWCTL;
         `NDR_OFF_RESP: reg_dec = NDR_REG_RESP;
         `NDR_OFF_DISC: reg_dec = NDR_REG_DISC;
         `NDR_OFF_INTTYPE: reg_dec = NDR_REG_INTTYPE;
         `NDR_OFF_STATUS: reg_dec = NDR_REG_STATUS;
         default: reg_dec = NDR_REG_NONE;
      endcase
   endfunction

   logic [13:0] pins_s;
   logic lclk_s, a_data_s, a_sof_s, a_disc_valid_s, b_data_s, b_srf_s;
   logic [7:0] a_disc_val_s;
   ndr_sync #(.W(14)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({link_clk, a_rx_data, a_rx_sof, a_rx_disc_valid, a_rx_disc_val,
          b_rx_data, b_rx_srf}),
      .q(pins_s)
   );
   assign {lclk_s, a_data_s, a_sof_s, a_disc_valid_s, a_disc_val_s,
           b_data_s, b_srf_s} = pins_s;

   logic lclk_prev_reg, tick;
   logic master_reg, invert_reg, sw_en_reg;
   logic [7:0] resp_reg, disc_reg, int_type_reg;
   ndr_adj_t adj_reg;
   logic done_reg, miss_reg, disc_active_reg, done_sent_reg, got_srf_reg;
   ndr_cnt_t bit_cnt_reg, acc_cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lclk_prev_reg <= 1'b0;
      end else begin
         lclk_prev_reg <= lclk_s;
      end
   end
   assign tick = lclk_s & ~lclk_prev_reg;

   // Bus side
   ndr_reg_e sel;
   logic wr;
   assign sel = reg_dec(paddr);
   assign wr = psel & penable & pwrite & pready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (sel == NDR_REG_NONE);
         if (psel && !penable) begin
            unique case (sel)
               NDR_REG_CTRL: prdata <= {30'h0, invert_reg, master_reg};
               NDR_REG_SWCTL: prdata <= {31'h0, sw_en_reg};
               NDR_REG_RESP: prdata <= {24'h0, resp_reg};
               NDR_REG_DISC: prdata <= {24'h0, disc_reg};
               NDR_REG_INTTYPE: prdata <= {24'h0, int_type_reg};
               NDR_REG_STATUS: prdata <= {18'h0, adj_reg, 5'h0,
                  disc_active_reg, miss_reg, done_reg};
               NDR_REG_NONE: prdata <= 32'h0;
            endcase
         end
      end
   end

   // Timing arithmetic
   ndr_cnt_t base;
   logic signed [11:0] centre, arr, diff;
   logic frame_start, in_win, arrive, acc, late, early, deadline;
   logic own_lvl, done_ev;
   assign base = 11'(`NDR_RESP_MULT * resp_reg + `NDR_RESP_ADD);
   // Slave compares at B, so remove its own upstream pass delay
   assign centre = $signed({1'b0, base}) + 12'(adj_reg)
                   - (master_reg ? 12'sd0 : UP_S);
   assign arr = $signed({1'b0, bit_cnt_reg});
   assign diff = arr - centre;
   assign in_win = (diff >= -WIN_S) && (diff <= WIN_S);
   assign arrive = tick & b_srf_s & sw_en_reg;
   assign acc = arrive & in_win;
   assign late = arrive & (diff > WIN_S);
   assign early = arrive & (diff < -WIN_S);
   assign deadline = tick & sw_en_reg & ~got_srf_reg
                     & (arr == centre + WIN_S + 12'sd1);
   assign own_lvl = ~master_reg & ((~sw_en_reg & (bit_cnt_reg == base))
                    | (sw_en_reg & ~got_srf_reg
                    & (arr == centre + WIN_S + 12'sd1)));
   assign frame_start = master_reg ? (bit_cnt_reg == LAST_BIT) : a_sof_s;
   assign done_ev = master_reg & disc_active_reg & arrive & ~done_sent_reg;

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_reg <= 1'b0;
         invert_reg <= 1'b0;
         sw_en_reg <= 1'b0;
         disc_reg <= `NDR_DISC_RST;
      end else if (wr) begin
         if (sel == NDR_REG_CTRL) begin
            master_reg <= pwdata[`NDR_CTRL_MASTER_BIT];
            invert_reg <= pwdata[`NDR_CTRL_INV_BIT];
         end
         if (sel == NDR_REG_SWCTL) begin
            sw_en_reg <= pwdata[`NDR_SW_EN_BIT];
         end
         if (sel == NDR_REG_DISC) begin
            disc_reg <= pwdata[7:0];
         end
      end
   end

   // Response setting: discovery frame copy wins over software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_reg <= `NDR_RESP_RST;
      end else if (tick && !master_reg && !sw_en_reg && a_disc_valid_s
                   && a_sof_s) begin
         resp_reg <= a_disc_val_s;
      end else if (wr && sel == NDR_REG_RESP) begin
         resp_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_reg <= 11'h000;
         got_srf_reg <= 1'b0;
         acc_cnt_reg <= 11'h000;
      end else if (tick) begin
         bit_cnt_reg <= frame_start ? 11'h000 : bit_cnt_reg + 11'h001;
         if (arrive) begin
            got_srf_reg <= 1'b1;
         end else if (frame_start) begin
            got_srf_reg <= 1'b0;
         end
         if (acc) begin
            acc_cnt_reg <= bit_cnt_reg;
         end
      end
   end

   // Discovery phase: set wins over acceptance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disc_active_reg <= 1'b0;
         done_sent_reg <= 1'b0;
      end else begin
         if ((wr && sel == NDR_REG_DISC && master_reg)
             || (wr && sel == NDR_REG_SWCTL && !master_reg && !sw_en_reg
             && pwdata[`NDR_SW_EN_BIT])) begin
            disc_active_reg <= 1'b1;
         end else if (acc) begin
            disc_active_reg <= 1'b0;
         end
         if (wr && sel == NDR_REG_DISC) begin
            done_sent_reg <= 1'b0;
         end else if (done_ev) begin
            done_sent_reg <= 1'b1;
         end
      end
   end

   // Gradual shift, one bit per mistimed frame, clamped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adj_reg <= 6'sd0;
      end else if (disc_active_reg) begin
         if (late && adj_reg < ADJ_MAX) begin
            adj_reg <= adj_reg + 6'sd1;
         end else if (early && adj_reg > ADJ_MIN) begin
            adj_reg <= adj_reg - 6'sd1;
         end
      end
   end

   // Sticky events, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
         miss_reg <= 1'b0;
         int_type_reg <= 8'h00;
      end else begin
         if (done_ev) begin
            done_reg <= 1'b1;
            int_type_reg <= `NDR_DONE_CODE;
         end else if (wr && sel == NDR_REG_STATUS
                      && pwdata[`NDR_ST_DONE_BIT]) begin
            done_reg <= 1'b0;
            int_type_reg <= 8'h00;
         end
         if (deadline) begin
            miss_reg <= 1'b1;
         end else if (wr && sel == NDR_REG_STATUS
                      && pwdata[`NDR_ST_MISS_BIT]) begin
            miss_reg <= 1'b0;
         end
      end
   end

   // Pass delay lanes
   ndr_bit_if dn_lane ();
   ndr_bit_if up_lane ();
   assign dn_lane.tick = tick;
   assign dn_lane.din = {a_sof_s, a_data_s};
   assign up_lane.tick = tick;
   assign up_lane.din = {b_srf_s & sw_en_reg & in_win,
                         b_data_s ^ invert_reg};
   // Sof tick is bit zero here, so this lane needs its full depth
   ndr_delay #(.DEPTH(`NDR_DOWNSTREAM_PASS_DELAY)) u_dn (
      .pclk(pclk),
      .presetn(presetn),
      .lane(dn_lane)
   );
   ndr_delay #(.DEPTH(`NDR_UPSTREAM_PASS_DELAY - 1)) u_up (
      .pclk(pclk),
      .presetn(presetn),
      .lane(up_lane)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_tx_data <= 1'b0;
         a_tx_srf <= 1'b0;
         b_tx_data <= 1'b0;
         b_tx_sof <= 1'b0;
         b_tx_disc_valid <= 1'b0;
         b_tx_disc_val <= 8'h00;
      end else if (tick) begin
         a_tx_data <= ~master_reg & up_lane.dout[0];
         a_tx_srf <= ~master_reg & (up_lane.dout[1] | own_lvl);
         if (master_reg) begin
            b_tx_sof <= sw_en_reg & frame_start;
            b_tx_data <= sw_en_reg & invert_reg;
            b_tx_disc_valid <= sw_en_reg & disc_active_reg;
            b_tx_disc_val <= disc_reg;
         end else begin
            b_tx_sof <= sw_en_reg & dn_lane.dout[1];
            b_tx_data <= sw_en_reg & (dn_lane.dout[0] ^ invert_reg);
            b_tx_disc_valid <= sw_en_reg & a_disc_valid_s;
            b_tx_disc_val <= a_disc_val_s;
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_scf_out;
      tick && master_reg && sw_en_reg && frame_start |=> b_tx_sof;
   endproperty
   a_scf_out: assert property (p_scf_out)
      else $error("sync control frame not sent downstream");
   property p_own_srf;
      $rose(a_tx_srf) && !sw_en_reg && !master_reg
         |-> bit_cnt_reg == base + 11'h001;
   endproperty
   a_own_srf: assert property (p_own_srf)
      else $error("last slave response at wrong bit");
   property p_dn_delay;
      $rose(b_tx_sof) && !master_reg |-> bit_cnt_reg == 11'(`NDR_DOWNSTREAM_PASS_DELAY);
   endproperty
   a_dn_delay: assert property (p_dn_delay)
      else $error("downstream pass delay wrong");
   property p_up_delay;
      tick && up_lane.dout[1] && !master_reg
         |=> a_tx_srf && bit_cnt_reg == 11'(acc_cnt_reg + `NDR_UPSTREAM_PASS_DELAY);
   endproperty
   a_up_delay: assert property (p_up_delay)
      else $error("upstream pass delay wrong");
   property p_outside_dropped;
      tick && b_srf_s && sw_en_reg && (diff > WIN_S || diff < -WIN_S)
         |=> got_srf_reg && $stable(acc_cnt_reg);
   endproperty
   a_outside_dropped: assert property (p_outside_dropped)
      else $error("mistimed response forwarded");
   property p_adj_range;
      adj_reg >= ADJ_MIN && adj_reg <= ADJ_MAX;
   endproperty
   a_adj_range: assert property (p_adj_range)
      else $error("response adjustment out of range");
   property p_master_late;
      late && master_reg && disc_active_reg && adj_reg < ADJ_MAX
         |=> adj_reg == $past(adj_reg) + 6'sd1;
   endproperty
   a_master_late: assert property (p_master_late)
      else $error("master did not follow late response");
   property p_slave_early;
      early && !master_reg && disc_active_reg && adj_reg > ADJ_MIN
         |=> adj_reg == $past(adj_reg) - 6'sd1;
   endproperty
   a_slave_early: assert property (p_slave_early)
      else $error("slave did not follow early response");
   property p_miss_sub;
      deadline && !master_reg |=> a_tx_srf && miss_reg;
   endproperty
   a_miss_sub: assert property (p_miss_sub)
      else $error("missing response not substituted");
   property p_copy;
      tick && !master_reg && !sw_en_reg && a_disc_valid_s && a_sof_s
         |=> resp_reg == $past(a_disc_val_s);
   endproperty
   a_copy: assert property (p_copy)
      else $error("discovery time not copied");
   property p_done;
      done_ev |=> done_reg && int_type_reg == `NDR_DONE_CODE;
   endproperty
   a_done: assert property (p_done)
      else $error("discovery done not reported");
   property p_clean;
      acc |=> got_srf_reg;
   endproperty
   a_clean: assert property (p_clean)
      else $error("error flagged on accepted response");
   c_done: cover property (done_ev);
   c_miss: cover property (deadline && !master_reg);
   c_adjust: cover property (late && disc_active_reg ##[1:1000] acc);
endmodule

// *** sim/ndr_peer.sv ***
// Purpose: downstream neighbour node on the B side of the node
// Assumes: sees the node's B outputs at each link clock rise
// Notes: gap of FFh keeps the neighbour silent; data line never idles
`timescale 1ns/10ps
module ndr_peer (
   input wire logic link_clk,
   input wire logic b_tx_sof,
   input wire logic [7:0] gap,
   output logic b_rx_srf,
   output logic b_rx_data
);
   int cnt = -1;
   logic [7:0] pat = 8'hA5;
   // Answer a fixed number of bits after each control frame start
   always @(posedge link_clk) begin
      b_rx_data <= pat[0];
      pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
      b_rx_srf <= 1'b0;
      if (b_tx_sof && gap != 8'hFF)
         cnt <= gap;
      else if (cnt > 0)
         cnt <= cnt - 1;
      if (cnt == 0) begin
         b_rx_srf <= 1'b1;
         cnt <= -1;
      end
   end
endmodule

// *** sim/tb_node_discovery_response_timing.sv ***
// Purpose: self-checking bench of the discovery timing node
// Assumes: node as slave first, then as master after a second reset
// Notes: all link lines sampled at each link clock rise
`timescale 1ns/10ps
`include "ndr_defines.svh"
module tb_node_discovery_response_timing;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic link_clk, a_rx_data, a_rx_sof, a_rx_disc_valid;
   logic [7:0] a_rx_disc_val, b_tx_disc_val, gap, disc_seen;
   logic b_rx_data, b_rx_srf, a_tx_data, a_tx_srf;
   logic b_tx_data, b_tx_sof, b_tx_disc_valid;
   logic [63:0] ha, hbt, hbr, hat;
   logic [31:0] st = 32'h1D5D;
   int errors = 0;
   int samples_checked = 0;
   int tick = 0;
   int n_asrf = 0;
   int t_asof, t_bsof, t_bsrf, t_asrf;

   ndr_node #(.FRAME_BITS(64)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk(link_clk), .a_rx_data(a_rx_data),
      .a_rx_sof(a_rx_sof), .a_rx_disc_valid(a_rx_disc_valid),
      .a_rx_disc_val(a_rx_disc_val), .b_rx_data(b_rx_data),
      .b_rx_srf(b_rx_srf), .a_tx_data(a_tx_data), .a_tx_srf(a_tx_srf),
      .b_tx_data(b_tx_data), .b_tx_sof(b_tx_sof),
      .b_tx_disc_valid(b_tx_disc_valid), .b_tx_disc_val(b_tx_disc_val));

   ndr_peer peer (.link_clk(link_clk), .b_tx_sof(b_tx_sof), .gap(gap),
      .b_rx_srf(b_rx_srf), .b_rx_data(b_rx_data));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Odd offset keeps the link clock edges off the pclk edges
   initial begin
      link_clk = 1'b0;
      #3;
      forever #40 link_clk = ~link_clk;
   end

   function automatic logic [31:0] xs();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction

   // Both directions carry inverted data once the B inversion is set
   function automatic int fd(input logic [63:0] i, input logic [63:0] o);
      for (int d = 0; d < 30; d++)
         if (o[15:0] === ~i[d +: 16])
            return d;
      return 99;
   endfunction

   always @(posedge link_clk) begin
      a_rx_data <= ^xs();
      tick <= tick + 1;
      ha <= {ha[62:0], a_rx_data};
      hbt <= {hbt[62:0], b_tx_data};
      hbr <= {hbr[62:0], b_rx_data};
      hat <= {hat[62:0], a_tx_data};
      if (a_rx_sof) t_asof <= tick;
      if (b_tx_sof) t_bsof <= tick;
      if (b_rx_srf) t_bsrf <= tick;
      if (a_tx_srf) begin
         t_asrf <= tick;
         n_asrf <= n_asrf + 1;
      end
      if (b_tx_disc_valid) disc_seen <= b_tx_disc_val;
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic rng(input string n, input int lo, input int hi,
                      input int v);
      samples_checked++;
      if (v < lo || v > hi) begin
         errors++;
         $display("[ERR] %s exp %0d..%0d got %0d", n, lo, hi, v);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int k;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      chk("pready wait", 32'h1, k);
      {psel, penable} <= 2'b00;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask

   task automatic frame(input logic dv, input logic [7:0] v, input int n);
      @(posedge link_clk);
      {a_rx_sof, a_rx_disc_valid, a_rx_disc_val} <= {1'b1, dv, v};
      @(posedge link_clk);
      {a_rx_sof, a_rx_disc_valid} <= 2'b00;
      repeat (n) @(posedge link_clk);
   endtask

   initial begin
      logic [31:0] v;
      logic e;
      logic [7:0] r;
      int n0;
      logic [7:0] offs [6] = '{`NDR_OFF_CTRL, `NDR_OFF_SWCTL,
         `NDR_OFF_RESP, `NDR_OFF_DISC, `NDR_OFF_INTTYPE, `NDR_OFF_STATUS};
      logic [31:0] rst_v [6] = '{32'h0, 32'h0, 32'h80, 32'h0, 32'h0, 32'h0};
      logic [7:0] dv [2] = '{8'h80, 8'h7C};
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {a_rx_sof, a_rx_disc_valid, a_rx_disc_val} = '0;
      gap = 8'hFF;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      foreach (offs[i]) begin
         rd(offs[i], v);
         chk("reset value", rst_v[i], v);
      end
      apb(1'b1, 8'h18, 32'hFFFFFFFF, v, e);
      apb(1'b0, 8'h18, 32'h0, v, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, v);
      // Slave target of discovery, then last node of the chain
      r = 8'(4 + xs() % 4);
      frame(1'b1, r, 40);
      frame(1'b0, 8'h00, 40);
      rd(`NDR_OFF_RESP, v);
      chk("response setting", {24'h0, r}, v);
      rng("last slave response", 4*r+6, 4*r+8, t_asrf - t_asof);
      wr(`NDR_OFF_CTRL, 32'h2);
      wr(`NDR_OFF_SWCTL, 32'h1);
      gap <= 8'(4 * r - 4);
      n0 = n_asrf;
      frame(1'b0, 8'h00, 4 * r + 20);
      chk("own response", 32'h1, n_asrf - n0);
      repeat (6) frame(1'b0, 8'h00, 4 * r + 20);
      rd(`NDR_OFF_STATUS, v);
      chk("miss flag", 32'h1, {31'h0, v[1]});
      chk("discovery active", 32'h0, {31'h0, v[2]});
      rng("adjust", 4, 7, int'($signed(v[13:8])));
      wr(`NDR_OFF_STATUS, 32'h2);
      repeat (2) frame(1'b0, 8'h00, 4 * r + 20);
      rd(`NDR_OFF_STATUS, v);
      chk("miss after adjust", 32'h0, {31'h0, v[1]});
      rng("down sof delay", 5, 9, t_bsof - t_asof);
      rng("up response delay", 7, 11, t_asrf - t_bsrf);
      rng("down data delay", 5, 9, fd(ha, hbt));
      rng("up data delay", 7, 11, fd(hbr, hat));
      // Neighbour now answers early: expectation must pull back in
      wr(`NDR_OFF_SWCTL, 32'h0);
      gap <= 8'(4 * r - 12);
      wr(`NDR_OFF_SWCTL, 32'h1);
      repeat (6) frame(1'b0, 8'h00, 4 * r + 20);
      rd(`NDR_OFF_STATUS, v);
      chk("early discovery active", 32'h0, {31'h0, v[2]});
      rng("early adjust", -4, 0, int'($signed(v[13:8])));
      // Second reset, node now heads the chain
      presetn <= 1'b0;
      gap <= 8'hFF;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wr(`NDR_OFF_CTRL, 32'h3);
      wr(`NDR_OFF_RESP, {24'h0, r});
      wr(`NDR_OFF_SWCTL, 32'h1);
      // Long cable: first slave answers late, master must follow
      gap <= 8'(4 * r + 12);
      foreach (dv[i]) begin
         wr(`NDR_OFF_DISC, {24'h0, dv[i]});
         repeat (200) @(posedge link_clk);
         chk("discovery value", {24'h0, dv[i]}, {24'h0, disc_seen});
         rd(`NDR_OFF_INTTYPE, v);
         chk("interrupt type", {24'h0, `NDR_DONE_CODE}, v);
         rd(`NDR_OFF_STATUS, v);
         chk("done event", 32'h1, {31'h0, v[0]});
         rng("master adjust", -4, 15, int'($signed(v[13:8])));
         wr(`NDR_OFF_STATUS, 32'h1);
         rd(`NDR_OFF_STATUS, v);
         chk("done cleared", 32'h0, {31'h0, v[0]});
      end
      end_of_test();
   end

   // Whole run is near 100 us of link traffic
   initial begin
      #400000;
      errors++;
      end_of_test();
   end
endmodule
